// File: design/ais_pkg.sv
package ais_pkg;
    // axis words: 3 for channels 4..6, 2 for channels 7 and 8
    localparam int AXIS_COUNT = 5;
    localparam int GRP_A_AXES = 3;
    localparam int GRP_A_INPUTS = 16;
    localparam int GRP_B_INPUTS = 8;
    localparam int DIN_COUNT = 24;
    localparam int AXIS_IDX_W = 3;
    localparam int BITNUM_W = 6;
    localparam int IRQ_W = 10;

    // status word layout
    localparam int BIT_INDEX = 16;
    localparam int BIT_MEAS_ERR = 17;
    localparam int BIT_IDX_LATCH = 18;
    localparam int BIT_STB_LATCH = 19;
    localparam logic [15:0] CONN_MASK_A = 16'hFFFF;
    localparam logic [15:0] CONN_MASK_B = 16'h00FF;
    localparam int STB_POS_A_BASE = 13;
    localparam int STB_POS_B_BASE = 6;

    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STAT0 = 8'h00;
    localparam logic [7:0] OFS_STAT_END = 8'h14;
    localparam logic [7:0] OFS_QUERY = 8'h20;
    localparam logic [7:0] OFS_INV = 8'h24;
    localparam logic [7:0] OFS_IDXPOL = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

    // query register fields
    localparam int QRY_AXIS_LSB = 0;
    localparam int QRY_BIT_LSB = 8;
    localparam int QRY_RES_POS = 16;

    // values after reset
    localparam logic [23:0] INV_RST = 24'h00_0000;
    localparam logic [4:0] IDXPOL_RST = 5'h00;
    localparam logic [9:0] IRQ_MASK_RST = 10'h000;
    localparam logic [2:0] QRY_AXIS_RST = 3'h0;
    localparam logic [5:0] QRY_BIT_RST = 6'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/ais_chan.sv
`timescale 1ns/1ps
`default_nettype none
module ais_chan #(
    parameter logic [15:0] CONN_MASK = 16'hFFFF,
    parameter int STB_POS = 13
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] din_i,
    input wire logic [15:0] inv_i,
    input wire logic index_i,
    input wire logic idx_pol_i,
    input wire logic meas_err_i,
    input wire logic clr_i,
    output logic [31:0] word_o,
    output logic idx_edge_o,
    output logic stb_edge_o
);
    logic [15:0] lvl_ff;
    logic idx_ff;
    logic err_ff;
    logic idx_lat_ff;
    logic stb_lat_ff;
    logic idx_edge_ff;
    logic stb_edge_ff;

    // inversion before the word; unconnected bits forced to zero
    wire [15:0] nxt_lvl = (din_i ^ inv_i) & CONN_MASK;
    wire nxt_idx = index_i ^ idx_pol_i;
    // a polarity change may itself look like an index edge
    wire idx_rise = nxt_idx & ~idx_ff;
    wire stb_rise = nxt_lvl[STB_POS] & ~lvl_ff[STB_POS];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lvl_ff <= 16'h0000;
            idx_ff <= 1'b0;
            err_ff <= 1'b0;
            idx_lat_ff <= 1'b0;
            stb_lat_ff <= 1'b0;
            idx_edge_ff <= 1'b0;
            stb_edge_ff <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
            idx_ff <= nxt_idx;
            err_ff <= meas_err_i;
            // new edge wins over a read-clear in the same cycle
            idx_lat_ff <= idx_rise | (idx_lat_ff & ~clr_i);
            stb_lat_ff <= stb_rise | (stb_lat_ff & ~clr_i);
            idx_edge_ff <= idx_rise;
            stb_edge_ff <= stb_rise;
        end
    end

    assign word_o = {12'h000, stb_lat_ff, idx_lat_ff, err_ff, idx_ff, lvl_ff};
    assign idx_edge_o = idx_edge_ff;
    assign stb_edge_o = stb_edge_ff;
endmodule
`default_nettype wire

// File: design/ais_top.sv
// Contract
// - active input reads 1, inactive 0
// - axes 4..6: bits 0..15 are sixteen inputs
// - bits 13..15 strobe axes 4, 5, 6
// - axes 7,8: bits 0..7 inputs, 8..15 unconnected
// - bits 6, 7 strobe axes 7, 8
// - bit 16 is live index level
// - bit 17 is measurement acquisition error
// - bit 18 latches an index edge
// - bit 19 latches a strobe edge
// - bits 20..31 always read zero
// - single-bit query, bit number counts from 1
// - per-input inversion and index polarity configurable
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ais_top (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic [15:0] DIN_A_I,
    input wire logic [7:0] DIN_B_I,
    input wire logic [4:0] INDEX_I,
    input wire logic [4:0] MEAS_ERR_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic IRQ_O
);
    // write channel state
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    // read channel state
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    // configuration and status
    logic [23:0] inv_ff;
    logic [4:0] idxpol_ff;
    logic [9:0] irq_stat_ff;
    logic [9:0] irq_mask_ff;
    logic [2:0] qry_axis_ff;
    logic [5:0] qry_bit_ff;
    logic irq_ff;

    logic [31:0] word [ais_pkg::AXIS_COUNT];
    logic [4:0] idx_edge;
    logic [4:0] stb_edge;
    logic [4:0] rd_clr;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    genvar g;
    generate
        for (g = 0; g < ais_pkg::AXIS_COUNT; g++) begin : g_axis
            localparam bit IS_A = (g < ais_pkg::GRP_A_AXES);
            localparam int STB = IS_A ? ais_pkg::STB_POS_A_BASE + g
                                      : ais_pkg::STB_POS_B_BASE + g - ais_pkg::GRP_A_AXES;
            wire [15:0] din = IS_A ? DIN_A_I : {8'h00, DIN_B_I};
            wire [15:0] inv = IS_A ? inv_ff[15:0] : {8'h00, inv_ff[23:16]};
            ais_chan #(
                .CONN_MASK(IS_A ? ais_pkg::CONN_MASK_A : ais_pkg::CONN_MASK_B),
                .STB_POS(STB)
            ) u_chan (
                .clk_i(CLOCK_I),
                .rst_n_i(NRST_I),
                .din_i(din),
                .inv_i(inv),
                .index_i(INDEX_I[g]),
                .idx_pol_i(idxpol_ff[g]),
                .meas_err_i(MEAS_ERR_I[g]),
                .clr_i(rd_clr[g]),
                .word_o(word[g]),
                .idx_edge_o(idx_edge[g]),
                .stb_edge_o(stb_edge[g])
            );
        end
    endgenerate

    // single-bit query; out-of-range axis or bit number yields 0
    wire qry_axis_ok = (qry_axis_ff < 3'(ais_pkg::AXIS_COUNT));
    wire qry_bit_ok = (qry_bit_ff >= 6'h01) && (qry_bit_ff <= 6'h20);
    wire [4:0] qry_pos = 5'(qry_bit_ff - 6'h01);
    wire [31:0] qry_word = qry_axis_ok ? word[qry_axis_ff] : 32'h0000_0000;
    wire qry_res = qry_bit_ok & qry_word[qry_pos];
    wire [31:0] qry_rd = {15'h0000, qry_res, 2'h0, qry_bit_ff, 5'h00, qry_axis_ff};

    // write side: address and data may come in either order
    wire aw_take = S_AXI_AWVALID_I & awready_ff;
    wire w_take = S_AXI_WVALID_I & wready_ff;
    wire do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire nxt_aw_hold = ~do_wr & (aw_hold_ff | aw_take);
    wire nxt_w_hold = ~do_wr & (w_hold_ff | w_take);
    wire nxt_bvalid = do_wr | (bvalid_ff & ~S_AXI_BREADY_I);

    wire wr_query = do_wr & (awaddr_ff == ais_pkg::OFS_QUERY);
    wire wr_inv = do_wr & (awaddr_ff == ais_pkg::OFS_INV);
    wire wr_pol = do_wr & (awaddr_ff == ais_pkg::OFS_IDXPOL);
    wire wr_istat = do_wr & (awaddr_ff == ais_pkg::OFS_IRQ_STAT);
    wire wr_imask = do_wr & (awaddr_ff == ais_pkg::OFS_IRQ_MASK);
    // status words are read-only: a write there gets an error answer
    wire wr_ok = wr_query | wr_inv | wr_pol | wr_istat | wr_imask;

    // readback views for the read mux and the byte-lane merge; rb_qry feeds only the merge, rb_istat only the mux
    wire [31:0] rb_qry = {18'h0_0000, qry_bit_ff, 5'h00, qry_axis_ff};
    wire [31:0] rb_inv = {8'h00, inv_ff};
    wire [31:0] rb_pol = {27'h000_0000, idxpol_ff};
    wire [31:0] rb_istat = {22'h00_0000, irq_stat_ff};
    wire [31:0] rb_mask = {22'h00_0000, irq_mask_ff};
    wire [31:0] m_query = merge(rb_qry, wdata_ff, wstrb_ff);
    wire [31:0] m_inv = merge(rb_inv, wdata_ff, wstrb_ff);
    wire [31:0] m_pol = merge(rb_pol, wdata_ff, wstrb_ff);
    wire [31:0] m_mask = merge(rb_mask, wdata_ff, wstrb_ff);
    wire [2:0] m_qry_axis = m_query[ais_pkg::QRY_AXIS_LSB +: 3];
    wire [5:0] m_qry_bit = m_query[ais_pkg::QRY_BIT_LSB +: 6];
    wire [31:0] w1c = merge(32'h0000_0000, wdata_ff, wstrb_ff);
    wire [9:0] istat_clr = wr_istat ? w1c[9:0] : 10'h000;
    // events win over a write-one-clear in the same cycle
    wire [9:0] istat_set = {stb_edge, idx_edge};
    wire [9:0] nxt_istat = istat_set | (irq_stat_ff & ~istat_clr);

    // read side: one cycle from address handshake to data
    wire ar_take = S_AXI_ARVALID_I & arready_ff;
    wire nxt_rvalid = ar_take | (rvalid_ff & ~S_AXI_RREADY_I);
    wire [7:0] ra = S_AXI_ARADDR_I;
    wire rd_stat = (ra < ais_pkg::OFS_STAT_END) && (ra[1:0] == 2'h0);
    wire [2:0] rd_axis = ra[4:2];
    wire sel_qry = (ra == ais_pkg::OFS_QUERY);
    wire sel_inv = (ra == ais_pkg::OFS_INV);
    wire sel_pol = (ra == ais_pkg::OFS_IDXPOL);
    wire sel_istat = (ra == ais_pkg::OFS_IRQ_STAT);
    wire sel_mask = (ra == ais_pkg::OFS_IRQ_MASK);
    wire rd_known = rd_stat | sel_qry | sel_inv | sel_pol | sel_istat | sel_mask;
    wire [31:0] rd_mux = rd_stat ? word[rd_axis] :
                         sel_qry ? qry_rd :
                         sel_inv ? rb_inv :
                         sel_pol ? rb_pol :
                         sel_istat ? rb_istat :
                         sel_mask ? rb_mask :
                         32'h0000_0000;

    // reading a status word acknowledges its latched edges
    generate
        for (g = 0; g < ais_pkg::AXIS_COUNT; g++) begin : g_clr
            assign rd_clr[g] = ar_take & rd_stat & (rd_axis == 3'(g));
        end
    endgenerate

    // handshake state: each ready falls once its half is held
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awready_ff <= ~nxt_aw_hold;
            wready_ff <= ~nxt_w_hold;
            bvalid_ff <= nxt_bvalid;
        end
    end

    // address held until the write executes
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            awaddr_ff <= 8'h00;
        end else if (aw_take) begin
            awaddr_ff <= S_AXI_AWADDR_I;
        end
    end

    // data may arrive before the address; it waits here with its strobes
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (w_take) begin
            wdata_ff <= S_AXI_WDATA_I;
            wstrb_ff <= S_AXI_WSTRB_I;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            bresp_ff <= ais_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bresp_ff <= wr_ok ? ais_pkg::RESP_OKAY : ais_pkg::RESP_SLVERR;
        end
    end

    // arready stays low while a read answer is pending
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= ~nxt_rvalid;
        end
    end

    // data and response are frozen at the address handshake
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= ais_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rdata_ff <= rd_mux;
            rresp_ff <= rd_known ? ais_pkg::RESP_OKAY : ais_pkg::RESP_SLVERR;
        end
    end

    // inversion and polarity changes can themselves make an edge
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            inv_ff <= ais_pkg::INV_RST;
        end else if (wr_inv) begin
            inv_ff <= m_inv[23:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            idxpol_ff <= ais_pkg::IDXPOL_RST;
        end else if (wr_pol) begin
            idxpol_ff <= m_pol[4:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            irq_mask_ff <= ais_pkg::IRQ_MASK_RST;
        end else if (wr_imask) begin
            irq_mask_ff <= m_mask[9:0];
        end
    end

    // query fields are kept as written, even out of range; the lookup masks them
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            qry_axis_ff <= ais_pkg::QRY_AXIS_RST;
            qry_bit_ff <= ais_pkg::QRY_BIT_RST;
        end else if (wr_query) begin
            qry_axis_ff <= m_qry_axis;
            qry_bit_ff <= m_qry_bit;
        end
    end

    // irq follows the next sticky value, so it rises with the status bit
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            irq_stat_ff <= 10'h000;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_istat;
            irq_ff <= |(nxt_istat & irq_mask_ff);
        end
    end

    assign S_AXI_AWREADY_O = awready_ff;
    assign S_AXI_WREADY_O = wready_ff;
    assign S_AXI_BVALID_O = bvalid_ff;
    assign S_AXI_BRESP_O = bresp_ff;
    assign S_AXI_ARREADY_O = arready_ff;
    assign S_AXI_RVALID_O = rvalid_ff;
    assign S_AXI_RDATA_O = rdata_ff;
    assign S_AXI_RRESP_O = rresp_ff;
    assign IRQ_O = irq_ff;
endmodule
`default_nettype wire

// File: verification/ais_field.sv
`timescale 1ns/1ps
`default_nettype none
module ais_field (
    input wire logic clk_i,
    input wire logic [15:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic [4:0] idx_i,
    input wire logic [4:0] err_i,
    output logic [15:0] a_o,
    output logic [7:0] b_o,
    output logic [4:0] idx_o,
    output logic [4:0] err_o
);
    // switch levels change only just after an edge, so each change is one clean edge
    always_ff @(posedge clk_i) begin
        a_o <= a_i;
        b_o <= b_i;
        idx_o <= idx_i;
        err_o <= err_i;
    end
endmodule
`default_nettype wire

// File: verification/ais_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ais_checker (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic [4:0] MEAS_ERR_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);
    logic [4:0] me_d_ff;
    logic [7:0] ra_ff;
    logic re_ff;
    wire ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire rd_stat = ra_ff <= 8'h10 && ra_ff[1:0] == 2'h0;
    wire rd_map = rd_stat || (ra_ff >= 8'h20 && ra_ff <= 8'h30 && ra_ff[1:0] == 2'h0);
    // the word holds the level sampled one edge before the read is taken
    always_ff @(posedge CLOCK_I) begin
        me_d_ff <= MEAS_ERR_I;
        ra_ff <= ar_hs ? S_AXI_ARADDR_I : ra_ff;
        re_ff <= ar_hs ? me_d_ff[S_AXI_ARADDR_I[4:2]] : re_ff;
    end
    property p_aw_hold;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O;
    endproperty
    a_aw_hold: assert property (p_aw_hold) else $error("awready not dropped");
    property p_b_lat;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
            && !S_AXI_BVALID_O |-> ##[1:2] S_AXI_BVALID_O;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_b_stand;
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
    endproperty
    a_b_stand: assert property (p_b_stand) else $error("write response dropped");
    property p_r_lat;
        ar_hs |=> S_AXI_RVALID_O;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_stand;
        S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data dropped");
    property p_ar_block;
        S_AXI_RVALID_O |-> !S_AXI_ARREADY_O;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
    property p_hi_zero;
        $rose(S_AXI_RVALID_O) && rd_stat |-> S_AXI_RDATA_O[31:20] == 12'h000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
    property p_unconn;
        S_AXI_RVALID_O && (ra_ff == 8'h0c || ra_ff == 8'h10) |-> S_AXI_RDATA_O[15:8] == 8'h00;
    endproperty
    a_unconn: assert property (p_unconn) else $error("unconnected bits set");
    property p_err_lvl;
        S_AXI_RVALID_O && rd_stat |-> S_AXI_RDATA_O[17] == re_ff;
    endproperty
    a_err_lvl: assert property (p_err_lvl) else $error("error bit wrong");
    property p_unmap;
        S_AXI_RVALID_O && !rd_map |-> S_AXI_RRESP_O == ais_pkg::RESP_SLVERR
            && S_AXI_RDATA_O == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
endmodule
bind ais_top ais_checker u_chk (.*);
`default_nettype wire

// File: verification/tb_axis_input_status_word.sv
`timescale 1ns/1ps
`default_nettype none
module tb_axis_input_status_word;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] din_a = 16'h0000;
    logic [7:0] din_b = 8'h00;
    logic [4:0] idx = 5'h00, err = 5'h00, pol = 5'h00, lat_i = 5'h00, lat_s = 5'h00;
    logic [23:0] inv = 24'h00_0000;
    logic [9:0] irq_s = 10'h000;
    logic [15:0] f_a;
    logic [7:0] f_b, awaddr = 8'h00, araddr = 8'h00;
    logic [4:0] f_i, f_e;
    logic [31:0] wdata = 32'h0000_0000, rdat, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq;
    logic [1:0] bresp, rresp, resp;
    int err_count = 0, num_checks = 0, seed = 68;
    always #25 clk = ~clk;
    ais_field u_fld (.clk_i(clk), .a_i(din_a), .b_i(din_b), .idx_i(idx), .err_i(err),
        .a_o(f_a), .b_o(f_b), .idx_o(f_i), .err_o(f_e));
    ais_top uut (.CLOCK_I(clk), .NRST_I(nrst), .DIN_A_I(f_a), .DIN_B_I(f_b), .INDEX_I(f_i),
        .MEAS_ERR_I(f_e), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(w_rdy), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(b_vld), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(ar_rdy), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(r_vld), .S_AXI_RREADY_I(rready), .IRQ_O(irq));
    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ready for the answer is offered with the request and held until it comes
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && aw_rdy) awvalid <= 1'b0;
            if (wvalid && w_rdy) wvalid <= 1'b0;
        end while (!(b_vld && bready) && n < 40);
        bready <= 1'b0;
        if (n >= 40) err_count++;
        if (n >= 40) stop_test();
        chk(32'(bresp), 32'(er));
    endtask
    task rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && ar_rdy) arvalid <= 1'b0;
        end while (!(r_vld && rready) && n < 40);
        rready <= 1'b0;
        rdat = rdata;
        resp = rresp;
        if (n >= 40) err_count++;
        if (n >= 40) stop_test();
    endtask
    function automatic logic [15:0] eff(int ax);
        return (ax < 3) ? (din_a ^ inv[15:0]) : {8'h00, din_b ^ inv[23:16]};
    endfunction
    function automatic logic [9:0] evt();
        logic [9:0] v;
        logic [15:0] e;
        for (int ax = 0; ax < 5; ax++) begin
            e = eff(ax);
            v[ax] = idx[ax] ^ pol[ax];
            v[5 + ax] = e[(ax < 3) ? 13 + ax : 3 + ax];
        end
        return v;
    endfunction
    function automatic logic [31:0] exp_word(int ax);
        return {12'h000, lat_s[ax], lat_i[ax], err[ax], idx[ax] ^ pol[ax], eff(ax)};
    endfunction
    task settle(input logic [9:0] b);
        logic [9:0] r;
        @(posedge clk);
        r = evt() & ~b;
        lat_i |= r[4:0];
        lat_s |= r[9:5];
        irq_s |= r;
        repeat (4) @(posedge clk);
    endtask
    task sw(input int ax);
        rd(8'(ax * 4));
        chk(rdat, exp_word(ax));
        lat_i[ax] = 1'b0;
        lat_s[ax] = 1'b0;
    endtask
    initial begin
        logic [9:0] b;
        logic [2:0] qa;
        logic [5:0] qn;
        logic [31:0] ew;
        logic qb;
        repeat (10) @(posedge clk);
        chk(32'({aw_rdy, w_rdy, ar_rdy, b_vld, r_vld, irq}), 32'h0000_0038);
        nrst <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            b = evt();
            if (i < 2) {din_a, din_b, idx, err} <= i ? '0 : '1;
            else {din_a, din_b, idx, err} <= 34'({$random(seed), $random(seed)});
            settle(b);
            if (i % 4 == 3) begin
                b = evt();
                inv = 24'($random(seed));
                pol = 5'($random(seed));
                wr(ais_pkg::OFS_INV, 32'(inv), 2'h0);
                wr(ais_pkg::OFS_IDXPOL, 32'(pol), 2'h0);
                settle(b);
            end
            for (int ax = 0; ax < 10; ax++) sw(ax % 5);
        end
        rd(ais_pkg::OFS_INV);
        chk(rdat, 32'(inv));
        for (int i = 0; i < 24; i++) begin
            qa = (i < 2) ? 3'(4 * i) : 3'($unsigned($random(seed)) % 5);
            qn = (i == 2) ? 6'h00 : (i == 3) ? 6'h21 : (i == 4) ? 6'h20
                : 6'(1 + $unsigned($random(seed)) % 32);
            ew = exp_word(int'(qa));
            qb = (qa < 5 && qn >= 1 && qn <= 32) ? ew[qn - 1] : 1'b0;
            wr(ais_pkg::OFS_QUERY, {18'h0_0000, qn, 5'h00, qa}, 2'h0);
            rd(ais_pkg::OFS_QUERY);
            chk(rdat, {15'h0000, qb, 2'h0, qn, 5'h00, qa});
        end
        b = evt();
        idx <= pol;
        settle(b);
        wr(ais_pkg::OFS_IRQ_MASK, 32'h0000_03ff, 2'h0);
        wr(ais_pkg::OFS_IRQ_STAT, 32'h0000_03ff, 2'h0);
        irq_s = 10'h000;
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        b = evt();
        idx <= ~pol;
        settle(b);
        chk(32'(irq), 32'h0000_0001);
        rd(ais_pkg::OFS_IRQ_STAT);
        chk(rdat, 32'(irq_s));
        wr(ais_pkg::OFS_IRQ_MASK, 32'h0000_0000, 2'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        wr(ais_pkg::OFS_IRQ_MASK, 32'h0000_03ff, 2'h0);
        wr(ais_pkg::OFS_IRQ_STAT, 32'h0000_03ff, 2'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        rd(8'h14);
        chk({rdat[29:0], resp}, 32'h0000_0002);
        wr(8'h00, 32'hffff_ffff, 2'h2);
        wr(8'h1c, 32'hffff_ffff, 2'h2);
        for (int ax = 0; ax < 5; ax++) sw(ax);
        stop_test();
    end
endmodule
`default_nettype wire
